// >>> cfg_loader_pkg.sv
`default_nettype none
package cfg_loader_pkg;
   // ========================================
   // Multi-mode pins and their codes
   localparam int NPIN = 4;
   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_FINE = 2;
   localparam int PIN_COARSE = 3;
   localparam logic [4:0] RES_IDX_MAX = 5'h1E;
   typedef enum logic [1:0] {
      CONN_LOW = 2'h0,
      CONN_OPEN = 2'h1,
      CONN_HIGH = 2'h2,
      CONN_RES = 2'h3
   } conn_e;
   typedef struct packed {
      logic is_res;
      logic [1:0] strap;
      logic [4:0] idx;
   } pin_code_s;
   typedef pin_code_s [NPIN-1:0] pin_codes_t;

   // ========================================
   // Derived settings, voltages in 10 mV units
   localparam int VOUT_W = 10;
   localparam int ADDR_W = 7;
   localparam logic [8:0][9:0] VOUT_TABLE = {10'h1F4, 10'h14A, 10'h0FA, 10'h0B4, 10'h096,
                                              10'h078, 10'h064, 10'h050, 10'h03C};
   localparam logic [9:0] VOUT_COARSE_STEP = 10'h019;
   localparam logic [9:0] VOUT_FALLBACK = 10'h03C;
   localparam logic [9:0] VOUT_MAX_DIV = 10'h00A;
   localparam logic [9:0] VOUT_SET_RST = 10'h03C;
   localparam logic [6:0] ADDR_BASE_DEF = 7'h20;

   // ========================================
   // Monitors and interrupts
   localparam int NMON = 5;
   localparam int MON_W = 12;
   localparam logic [11:0] MON_LIM_RST = 12'hFFF;
   typedef logic [NMON-1:0][MON_W-1:0] mon_vals_t;
   localparam int NIRQ = 6;
   localparam int IRQ_LOAD_BIT = 5;

   // ========================================
   // Register offsets and fields
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_PIN_CODES = 8'h08;
   localparam logic [7:0] OFF_BUS_ADDR = 8'h0C;
   localparam logic [7:0] OFF_VOUT_SET = 8'h10;
   localparam logic [7:0] OFF_VOUT_MAX = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;
   localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
   localparam logic [7:0] OFF_MON_VAL = 8'h40;
   localparam logic [7:0] OFF_MON_LIM = 8'h60;
   localparam int CTRL_RESTORE_BIT = 0;
   localparam int CTRL_SAVE_BIT = 1;
   localparam int STAT_LOADED_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_EN_BIT = 2;

   // ========================================
   // Timing and sequencing
   localparam int CLK_PERIOD_NS = 8;
   localparam int PIN_SETTLE_NS = 2000;
   localparam int PIN_SETTLE_CYC = (PIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      LD_IDLE = 2'h0,
      LD_SETTLE = 2'h1,
      LD_CAPTURE = 2'h3
   } ld_e;

   // ========================================
   // Bus carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;
   typedef struct packed {
      pin_codes_t codes;
      logic [9:0] vout_set;
   } nvm_img_s;
endpackage
`default_nettype wire

// >>> pin_frontend.sv
`default_nettype none
module pin_frontend
   import cfg_loader_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Pin classifier outputs, asynchronous
   input wire logic [NPIN-1:0][1:0] pin_kind,
   input wire logic [NPIN-1:0][4:0] pin_res_idx,
   input wire logic enable_pin,
   // Synchronised codes
   output var pin_codes_t pin_codes,
   output logic enable_sync
);
   typedef struct packed {
      logic [NPIN-1:0][6:0] s1;
      logic [NPIN-1:0][6:0] s2;
      logic en1;
      logic en2;
   } fe_s;
   fe_s st_r;
   fe_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < NPIN; i++) begin
         st_nxt.s1[i] = {pin_kind[i], pin_res_idx[i]};
      end
      st_nxt.s2 = st_r.s1;
      st_nxt.en1 = enable_pin;
      st_nxt.en2 = st_r.en1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign enable_sync = st_r.en2;

   // ========================================
   // Classification per pin
   for (genvar g = 0; g < NPIN; g++) begin : g_pin
      logic res;
      logic [4:0] idx;
      assign res = st_r.s2[g][6:5] == CONN_RES;
      assign idx = st_r.s2[g][4:0];
      assign pin_codes[g].is_res = res;
      // Strap code equals connection code for low, open and high
      assign pin_codes[g].strap = res ? 2'h0 : st_r.s2[g][6:5];
      // Out-of-range resistance clamps to the top selection
      assign pin_codes[g].idx = !res ? 5'h00 : (idx > RES_IDX_MAX) ? RES_IDX_MAX : idx;
   end
endmodule
`default_nettype wire

// >>> cfg_decoder.sv
`default_nettype none
module cfg_decoder
   import cfg_loader_pkg::*;
(
   // Codes in
   input var pin_codes_t pin_codes,
   input wire logic [ADDR_W-1:0] addr_base,
   // Derived settings out
   output logic [VOUT_W-1:0] vout_pin,
   output logic [VOUT_W-1:0] vout_max_pin,
   output logic [ADDR_W-1:0] bus_addr_pin
);
   pin_code_s fine;
   pin_code_s coarse;
   logic [6:0] a_val;
   logic [6:0] b_val;

   assign fine = pin_codes[PIN_FINE];
   assign coarse = pin_codes[PIN_COARSE];

   always_comb begin
      if (!fine.is_res && !coarse.is_res) begin
         vout_pin = VOUT_TABLE[4'(coarse.strap) * 4'h3 + 4'(fine.strap)];
      end else if (fine.is_res && coarse.is_res) begin
         vout_pin = 10'(fine.idx) + 10'(coarse.idx) * VOUT_COARSE_STEP;
      end else begin
         // Mixed strap and resistor has no defined voltage
         vout_pin = VOUT_FALLBACK;
      end
   end

   assign vout_max_pin = vout_pin + vout_pin / VOUT_MAX_DIV;

   assign a_val = pin_codes[PIN_A].is_res ? 7'(pin_codes[PIN_A].idx) :
                  7'(pin_codes[PIN_A].strap);
   assign b_val = pin_codes[PIN_B].is_res ? 7'(pin_codes[PIN_B].idx) :
                  7'(pin_codes[PIN_B].strap);
   assign bus_addr_pin = addr_base + a_val + b_val * 7'h03;
endmodule
`default_nettype wire

// >>> strap_pin_config_loader.sv
// Operation
// - Sample pins at power-up and on restore
// - Classify each pin into four connection kinds
// - Single strap pin gives low, open, high
// - Two strap pins give nine settings
// - Resistor pin decodes to up to 31
// - Pin-set parameters stay readable; only the set-point is writable
// - Bus address and ceiling only from pins
// - Bus address from two address pins
// - Ceiling is set-point plus ten percent
// - Configuration can be saved to storage
// - Enabled device runs on pin settings
// - Monitored values readable by host
// - Limits on monitored values raise alert
// - Enable input active high permits switching
// - Alert drives the dedicated alert line
//
// Our own choices: the APB register port and the register addresses.
`default_nettype none
module strap_pin_config_loader
   import cfg_loader_pkg::*;
#(
   parameter logic [ADDR_W-1:0] ADDR_BASE = ADDR_BASE_DEF
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register bus
   input var apb_req_s apb_in,
   output var apb_rsp_s apb_out,
   // Multi-mode pin classifier and enable pin
   input wire logic [NPIN-1:0][1:0] pin_kind,
   input wire logic [NPIN-1:0][4:0] pin_res_idx,
   input wire logic enable_pin,
   // Telemetry from converters
   input var mon_vals_t mon_values,
   // Settings to the power stage
   output logic pwm_enable,
   output logic [ADDR_W-1:0] bus_addr,
   output logic [VOUT_W-1:0] vout_set,
   output logic [VOUT_W-1:0] vout_max,
   // Non-volatile store
   output logic nvm_wr,
   output var nvm_img_s nvm_wdata,
   // Alerts
   output logic irq,
   output logic serial_alert_out
);
   localparam int CNT_W = $clog2(PIN_SETTLE_CYC + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(PIN_SETTLE_CYC - 1);

   typedef struct packed {
      ld_e ld;
      logic [CNT_W-1:0] cnt;
      logic loaded;
      pin_codes_t codes;
      logic [VOUT_W-1:0] pin_vout;
      logic [VOUT_W-1:0] vout_set;
      logic [VOUT_W-1:0] vout_max;
      logic [ADDR_W-1:0] bus_addr;
      mon_vals_t mon_lim;
      logic [NIRQ-1:0] irq_st;
      logic [NIRQ-1:0] irq_en;
      logic irq;
      logic alert;
      logic pwm_en;
      logic nvm_wr;
      nvm_img_s nvm_img;
      apb_rsp_s rsp;
   } state_s;

   state_s st_r;
   state_s st_nxt;
   pin_codes_t pin_codes;
   logic enable_sync;
   logic [VOUT_W-1:0] vout_pin;
   logic [VOUT_W-1:0] vout_max_pin;
   logic [ADDR_W-1:0] bus_addr_pin;
   logic acc;
   logic wr;
   logic hit;
   logic [31:0] rdata;
   logic restore;
   logic [NIRQ-1:0] set_vec;
   logic [NIRQ-1:0] clr_vec;
   logic [NMON-1:0] over;

   // ========================================
   // Pin front end and decoding
   pin_frontend u_frontend (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_kind(pin_kind),
      .pin_res_idx(pin_res_idx),
      .enable_pin(enable_pin),
      .pin_codes(pin_codes),
      .enable_sync(enable_sync)
   );

   cfg_decoder u_decoder (
      .pin_codes(pin_codes),
      .addr_base(ADDR_BASE),
      .vout_pin(vout_pin),
      .vout_max_pin(vout_max_pin),
      .bus_addr_pin(bus_addr_pin)
   );

   // ========================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      acc = apb_in.psel && apb_in.penable;
      wr = acc && st_r.rsp.pready && apb_in.pwrite;
      restore = 1'b0;
      clr_vec = '0;
      set_vec = '0;
      st_nxt.nvm_wr = 1'b0;

      // Read mux; misaligned or unknown addresses answer with an error
      rdata = '0;
      hit = 1'b1;
      case (apb_in.paddr)
         OFF_CTRL: rdata = '0;
         OFF_STATUS: begin
            rdata[STAT_LOADED_BIT] = st_r.loaded;
            rdata[STAT_BUSY_BIT] = st_r.ld != LD_IDLE;
            rdata[STAT_EN_BIT] = enable_sync;
         end
         OFF_PIN_CODES: rdata = 32'(st_r.codes);
         OFF_BUS_ADDR: rdata = 32'(st_r.bus_addr);
         OFF_VOUT_SET: rdata = 32'(st_r.vout_set);
         OFF_VOUT_MAX: rdata = 32'(st_r.vout_max);
         OFF_IRQ_STATUS: rdata = 32'(st_r.irq_st);
         OFF_IRQ_ENABLE: rdata = 32'(st_r.irq_en);
         OFF_IRQ_CLEAR: rdata = '0;
         default: begin
            hit = 1'b0;
            for (int i = 0; i < NMON; i++) begin
               if (apb_in.paddr == OFF_MON_VAL + 8'(4 * i)) begin
                  hit = 1'b1;
                  rdata = 32'(mon_values[i]);
               end
               if (apb_in.paddr == OFF_MON_LIM + 8'(4 * i)) begin
                  hit = 1'b1;
                  rdata = 32'(st_r.mon_lim[i]);
               end
            end
         end
      endcase

      // One wait state, then the completing edge
      st_nxt.rsp.pready = acc && !st_r.rsp.pready;
      if (acc && !st_r.rsp.pready) begin
         st_nxt.rsp.prdata = apb_in.pwrite ? 32'h0000_0000 : rdata;
         st_nxt.rsp.pslverr = !hit;
      end else begin
         st_nxt.rsp.prdata = '0;
         st_nxt.rsp.pslverr = 1'b0;
      end

      if (wr) begin
         case (apb_in.paddr)
            OFF_CTRL: begin
               restore = apb_in.pwdata[CTRL_RESTORE_BIT];
               if (apb_in.pwdata[CTRL_SAVE_BIT]) begin
                  st_nxt.nvm_wr = 1'b1;
                  st_nxt.nvm_img = '{codes: st_r.codes, vout_set: st_r.vout_set};
               end
            end
            OFF_VOUT_SET: st_nxt.vout_set = apb_in.pwdata[VOUT_W-1:0];
            OFF_IRQ_ENABLE: st_nxt.irq_en = apb_in.pwdata[NIRQ-1:0];
            OFF_IRQ_CLEAR: clr_vec = apb_in.pwdata[NIRQ-1:0];
            // Address and ceiling writes are accepted but change nothing
            OFF_BUS_ADDR, OFF_VOUT_MAX: st_nxt.bus_addr = st_r.bus_addr;
            default: begin
               for (int i = 0; i < NMON; i++) begin
                  if (apb_in.paddr == OFF_MON_LIM + 8'(4 * i)) begin
                     st_nxt.mon_lim[i] = apb_in.pwdata[MON_W-1:0];
                  end
               end
            end
         endcase
      end

      // Pin sampling sequence
      case (st_r.ld)
         LD_IDLE: begin
            if (restore) begin
               st_nxt.ld = LD_SETTLE;
               st_nxt.cnt = '0;
            end
         end
         LD_SETTLE: begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt == SETTLE_LAST) begin
               st_nxt.ld = LD_CAPTURE;
            end
         end
         LD_CAPTURE: begin
            st_nxt.ld = LD_IDLE;
            st_nxt.codes = pin_codes;
            st_nxt.pin_vout = vout_pin;
            st_nxt.vout_set = vout_pin;
            st_nxt.vout_max = vout_max_pin;
            st_nxt.bus_addr = bus_addr_pin;
            st_nxt.loaded = 1'b1;
            set_vec[IRQ_LOAD_BIT] = 1'b1;
         end
         default: st_nxt.ld = LD_IDLE;
      endcase

      for (int i = 0; i < NMON; i++) begin
         over[i] = mon_values[i] > st_r.mon_lim[i];
      end
      set_vec[NMON-1:0] = over;
      // A new event beats a clear in the same cycle
      st_nxt.irq_st = (st_r.irq_st & ~clr_vec) | set_vec;
      st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_en);
      st_nxt.alert = st_nxt.irq;
      // Switching only once pin settings are in place
      st_nxt.pwm_en = enable_sync && st_nxt.loaded;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.ld <= LD_SETTLE;
         st_r.vout_set <= VOUT_SET_RST;
         st_r.mon_lim <= {NMON{MON_LIM_RST}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apb_out = st_r.rsp;
   assign pwm_enable = st_r.pwm_en;
   assign bus_addr = st_r.bus_addr;
   assign vout_set = st_r.vout_set;
   assign vout_max = st_r.vout_max;
   assign nvm_wr = st_r.nvm_wr;
   assign nvm_wdata = st_r.nvm_img;
   assign irq = st_r.irq;
   assign serial_alert_out = st_r.alert;

   // ========================================
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_restore_wr;
      wr && apb_in.paddr == OFF_CTRL && apb_in.pwdata[CTRL_RESTORE_BIT] && st_r.ld == LD_IDLE;
   endsequence
   sequence s_settle_done;
      st_r.ld == LD_SETTLE && st_r.cnt == SETTLE_LAST;
   endsequence

   property p_restore;
      s_restore_wr |=> st_r.ld == LD_SETTLE && st_r.cnt == '0;
   endproperty
   a_restore: assert property (p_restore) else $error("restore did not start sampling");

   property p_capture;
      s_settle_done |=> st_r.ld == LD_CAPTURE ##1 st_r.ld == LD_IDLE && st_r.loaded;
   endproperty
   a_capture: assert property (p_capture) else $error("capture sequence broken");

   property p_hold_codes;
      st_r.ld == LD_IDLE ##1 st_r.ld == LD_IDLE |-> $stable(st_r.codes);
   endproperty
   a_hold_codes: assert property (p_hold_codes) else $error("codes changed while idle");

   property p_ceiling;
      st_r.loaded |-> st_r.vout_max == st_r.pin_vout + st_r.pin_vout / VOUT_MAX_DIV;
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("ceiling not ten percent above");

   property p_addr_fixed;
      st_r.ld == LD_IDLE |=> $stable(st_r.bus_addr) && $stable(st_r.vout_max);
   endproperty
   a_addr_fixed: assert property (p_addr_fixed) else $error("pin-only setting changed");

   property p_vout_write;
      wr && apb_in.paddr == OFF_VOUT_SET && st_r.ld != LD_CAPTURE
         |=> st_r.vout_set == $past(apb_in.pwdata[VOUT_W-1:0]);
   endproperty
   a_vout_write: assert property (p_vout_write) else $error("set-point write lost");

   property p_alert;
      irq == |(st_r.irq_st & st_r.irq_en) && serial_alert_out == irq;
   endproperty
   a_alert: assert property (p_alert) else $error("alert line disagrees with status");

   property p_limit;
      over[0] |=> st_r.irq_st[0];
   endproperty
   a_limit: assert property (p_limit) else $error("limit crossing not flagged");

   property p_enable;
      !enable_sync |=> !pwm_enable;
   endproperty
   a_enable: assert property (p_enable) else $error("switching without enable");

   property p_ready;
      acc && !apb_out.pready |=> apb_out.pready ##1 !apb_out.pready;
   endproperty
   a_ready: assert property (p_ready) else $error("bus answer timing wrong");
endmodule
`default_nettype wire

// >>> strap_board.sv
`default_nettype none
module strap_board
   import cfg_loader_pkg::*;
(
   // Board straps chosen by the bench
   input wire logic ref_clk,
   input wire logic [NPIN-1:0][1:0] conn,
   input wire logic [NPIN-1:0][4:0] ridx,
   input wire logic en_req,
   // Classifier view of the pins
   output logic [NPIN-1:0][1:0] pin_kind,
   output logic [NPIN-1:0][4:0] pin_res_idx,
   output logic enable_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] junk_r = 5'h15;
   // ========
   // Pin classifier
   // No resistor to measure: the index means nothing, so it wanders
   always @(posedge ref_clk) begin
      junk_r <= ~junk_r;
   end
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         pin_kind[i] = conn[i];
         pin_res_idx[i] = (conn[i] == 2'h3) ? ridx[i] : junk_r;
      end
   end
   // Grounded unless the bench wants switching
   assign enable_pin = en_req;
endmodule
`default_nettype wire

// >>> strap_pin_config_loader_test.sv
`default_nettype none
module strap_pin_config_loader_test
   import cfg_loader_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] kf;
      logic [4:0] xf;
      logic [1:0] kc;
      logic [4:0] xc;
      logic [9:0] v;
   } row_s;
   localparam row_s ROWS [12] = '{
      '{2'h0, 5'h00, 2'h0, 5'h00, 10'h03C}, '{2'h1, 5'h00, 2'h0, 5'h00, 10'h050},
      '{2'h2, 5'h00, 2'h0, 5'h00, 10'h064}, '{2'h0, 5'h00, 2'h1, 5'h00, 10'h078},
      '{2'h1, 5'h00, 2'h1, 5'h00, 10'h096}, '{2'h2, 5'h00, 2'h1, 5'h00, 10'h0B4},
      '{2'h0, 5'h00, 2'h2, 5'h00, 10'h0FA}, '{2'h1, 5'h00, 2'h2, 5'h00, 10'h14A},
      '{2'h2, 5'h00, 2'h2, 5'h00, 10'h1F4}, '{2'h3, 5'h08, 2'h3, 5'h05, 10'h085},
      '{2'h3, 5'h1F, 2'h3, 5'h00, 10'h01E}, '{2'h3, 5'h04, 2'h0, 5'h00, 10'h03C}};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   apb_req_s apb_in = '0;
   apb_rsp_s apb_out;
   logic [NPIN-1:0][1:0] conn = {NPIN{2'h2}};
   logic [NPIN-1:0][4:0] ridx = '0;
   logic en_req = 1'b0;
   mon_vals_t mon_values = '0;
   logic [NPIN-1:0][1:0] pin_kind;
   logic [NPIN-1:0][4:0] pin_res_idx;
   logic enable_pin;
   logic pwm_enable;
   logic [ADDR_W-1:0] bus_addr;
   logic [VOUT_W-1:0] vout_set;
   logic [VOUT_W-1:0] vout_max;
   logic nvm_wr;
   nvm_img_s nvm_wdata;
   logic irq;
   logic serial_alert_out;
   int fail_count = 0;
   int checked = 0;
   logic [31:0] q;
   logic e;
   row_s r;
   logic [6:0] ea;

   always #4 ref_clk = ~ref_clk;

   strap_board board (.ref_clk(ref_clk), .conn(conn), .ridx(ridx), .en_req(en_req),
      .pin_kind(pin_kind), .pin_res_idx(pin_res_idx), .enable_pin(enable_pin));

   strap_pin_config_loader #(.ADDR_BASE(ADDR_BASE_DEF)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .apb_in(apb_in), .apb_out(apb_out), .pin_kind(pin_kind), .pin_res_idx(pin_res_idx),
      .enable_pin(enable_pin), .mon_values(mon_values), .pwm_enable(pwm_enable),
      .bus_addr(bus_addr), .vout_set(vout_set), .vout_max(vout_max), .nvm_wr(nvm_wr),
      .nvm_wdata(nvm_wdata), .irq(irq), .serial_alert_out(serial_alert_out));

   // ========
   // Reporting
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] x);
      checked++;
      if (seen !== x) begin
         fail_count++;
         $display("Error %s expected %h seen %h", s, x, seen);
      end
   endtask
   task automatic give_up();
      fail_count++;
      print_verdict();
   endtask

   // ========
   // Bus master
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      apb_in <= '{1'b1, 1'b0, w, a, d};
      @(posedge ref_clk);
      apb_in.penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (apb_out.pready !== 1'b1 && n < 20);
      if (n >= 20) give_up();
      q = apb_out.prdata;
      e = apb_out.pslverr;
      apb_in.psel <= 1'b0;
      apb_in.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input string s, input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h0);
      check(s, q, x);
   endtask
   // Loaded and not sampling; bounded because a lost capture must not hang
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, OFF_STATUS, 32'h0);
         n++;
      end while (q[1:0] !== 2'b01 && n < 200);
      if (n >= 200) give_up();
   endtask
   function automatic logic [6:0] pv(logic [1:0] k, logic [4:0] x);
      return (k == 2'h3) ? ((x > 5'h1E) ? 7'h1E : {2'h0, x}) : {5'h00, k};
   endfunction

   // ========
   // Sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_idle();
      check("pwr_vout", vout_set, 32'h1F4);
      check("pwr_addr", bus_addr, 32'h28);
      rd("irq_en", OFF_IRQ_ENABLE, 32'h0);
      rd("mon_lim", OFF_MON_LIM, 32'hFFF);
      rd("irq_st", OFF_IRQ_STATUS, 32'h20);
      for (int i = 0; i < 12; i++) begin
         r = ROWS[i];
         conn <= {r.kc, r.kf, r.kc, r.kf};
         ridx <= {r.xc, r.xf, r.xc, r.xf};
         wr(OFF_CTRL, 32'h1);
         wait_idle();
         rd("vout_set", OFF_VOUT_SET, r.v);
         rd("vout_max", OFF_VOUT_MAX, r.v + r.v / 10);
         check("vout_max_out", vout_max, r.v + r.v / 10);
         // Address wraps at seven bits
         ea = ADDR_BASE_DEF + pv(r.kf, r.xf) + 7'h03 * pv(r.kc, r.xc);
         check("bus_addr", bus_addr, 32'(ea));
         bus(1'b0, OFF_PIN_CODES, 32'h0);
         check("is_res", q[23], r.kf == 2'h3);
         if (r.kf == 2'h3) check("idx", q[20:16], pv(r.kf, r.xf));
         else check("strap", q[22:21], r.kf);
      end
      wr(OFF_VOUT_SET, 32'hAB);
      rd("vout_rw", OFF_VOUT_SET, 32'hAB);
      wr(OFF_BUS_ADDR, 32'h7F);
      wr(OFF_VOUT_MAX, 32'h3FF);
      rd("addr_ro", OFF_BUS_ADDR, 32'h24);
      rd("max_ro", OFF_VOUT_MAX, 32'h42);
      rd("unmapped", 8'h24, 32'h0);
      check("unmapped_err", e, 1'b1);
      bus(1'b1, 8'h11, 32'h55);
      check("misalign_err", e, 1'b1);
      rd("vout_kept", OFF_VOUT_SET, 32'hAB);
      // Save image
      wr(OFF_CTRL, 32'h2);
      for (int n = 0; n < 10 && nvm_wr !== 1'b1; n++) @(posedge ref_clk);
      check("nvm_wr", nvm_wr, 1'b1);
      check("nvm_vout", nvm_wdata.vout_set, 32'hAB);
      // Last capture: address pin A and the fine pin on resistor index 4, the others low
      check("nvm_codes", nvm_wdata.codes, 32'h0084_0084);
      // Monitor limit, mask, sticky re-set, clear
      wr(OFF_IRQ_CLEAR, 32'h3F);
      rd("irq_clr", OFF_IRQ_STATUS, 32'h0);
      wr(OFF_MON_LIM, 32'hFF);
      mon_values[0] <= 12'h100;
      rd("mon_val", OFF_MON_VAL, 32'h100);
      rd("irq_mon", OFF_IRQ_STATUS, 32'h1);
      check("irq_masked", irq, 1'b0);
      wr(OFF_IRQ_ENABLE, 32'h1);
      repeat (2) @(posedge ref_clk);
      check("irq_on", irq, 1'b1);
      check("alert_on", serial_alert_out, 1'b1);
      wr(OFF_IRQ_CLEAR, 32'h1);
      rd("irq_reset", OFF_IRQ_STATUS, 32'h1);
      mon_values[0] <= 12'h000;
      wr(OFF_IRQ_CLEAR, 32'h1);
      repeat (2) @(posedge ref_clk);
      check("alert_off", serial_alert_out, 1'b0);
      // Enable pin
      en_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check("pwm_on", pwm_enable, 1'b1);
      rd("status_en", OFF_STATUS, 32'h5);
      en_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check("pwm_off", pwm_enable, 1'b0);
      // Pins moved without restore, then a second reset
      conn <= {NPIN{2'h1}};
      repeat (10) @(posedge ref_clk);
      check("addr_held", bus_addr, 32'h24);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_idle();
      check("rst_vout", vout_set, 32'h096);
      check("rst_addr", bus_addr, 32'h24);
      print_verdict();
   end
endmodule
`default_nettype wire
